/* shared/thcfg_pkg.sv */
// package: offsets, fields, reset values and types of the thermal config block
package thcfg_pkg;

    // ****************************************************************
    // register offsets on the host serial register port
    // ****************************************************************
    localparam logic [7:0] THERMAL_CFG2_ADDR = 8'h17; // thermal zone config two
    localparam logic [7:0] HARVEST_CFG0_ADDR = 8'h18; // harvester config zero

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int MON_SEL_LO   = 6; // monitor select, bits 7:6
    localparam int UNUSED_BIT   = 5; // always reads zero
    localparam int WARM_DROP_LO = 3; // warm regulation drop, bits 4:3
    localparam int WARM_CUR_LO  = 0; // warm current scale, bits 2:0
    localparam int PATH_LO      = 6; // harvest path mode, bits 7:6
    localparam int RECHG_LO     = 4; // recharge offset, bits 5:4
    localparam int THRESH_LO    = 0; // regulation threshold, bits 3:0

    // ****************************************************************
    // reset values (plain defaults)
    // ****************************************************************
    localparam logic [7:0] THERMAL_CFG2_RST = 8'h00; // whole register
    localparam logic [7:0] HARVEST_CFG0_RST = 8'h00; // whole register
    localparam logic [7:0] CFG2_WRITE_MASK  = 8'hDF; // bit 5 unwritable
    localparam logic [7:0] CFG2_SUPPLY_MASK = 8'h1F; // supply-edge fields

    // ****************************************************************
    // codes
    // ****************************************************************
    localparam logic [1:0] MON_OFF       = 2'h0; // no periodic monitoring
    localparam logic [1:0] MON_COOL_ROOM = 2'h1; // cool and room allowed
    localparam logic [1:0] MON_ROOM_WARM = 2'h2; // room and warm allowed
    localparam logic [1:0] MON_ALL       = 2'h3; // cool, room, warm allowed

    localparam logic [2:0] ZONE_COLD = 3'h0; // below cool
    localparam logic [2:0] ZONE_COOL = 3'h1; // cool zone
    localparam logic [2:0] ZONE_ROOM = 3'h2; // room zone
    localparam logic [2:0] ZONE_WARM = 3'h3; // warm zone
    localparam logic [2:0] ZONE_HOT  = 3'h4; // above warm

    // drop in 50mV steps for each warm regulation code
    localparam logic [1:0] DROP_CODE0 = 2'h3; // 150mV
    localparam logic [1:0] DROP_CODE1 = 2'h2; // 100mV
    localparam logic [1:0] DROP_CODE2 = 2'h1; // 50mV
    localparam logic [1:0] DROP_CODE3 = 2'h0; // no reduction
    localparam logic [3:0] CUR_BASE   = 4'h2; // code 000 is 0.2x
    localparam logic [3:0] CUR_FULL   = 4'hA; // code 111 is 1.0x
    localparam logic [2:0] CUR_MAXC   = 3'h7; // full-current code

    localparam logic [1:0] PATH_DIRECT = 2'h0; // switch forced on
    localparam logic [1:0] PATH_AUTO   = 2'h1; // by threshold
    localparam logic [1:0] PATH_DIODE  = 2'h2; // ideal diode forced
    localparam logic       EDGE_RISE   = 1'b0; // reset on supply rising

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic [7:0] addr;   // register offset
        logic [7:0] wdata;  // write data
        logic       wr;     // write strobe
        logic       rd;     // read strobe
    } thcfg_req_t;

    typedef struct packed {
        logic [1:0] mon_sel;   // harvest_thermal_monitor_select
        logic       unused;    // reads zero
        logic [1:0] warm_drop; // warm_zone_regulation_drop
        logic [2:0] warm_cur;  // warm_zone_current_scale
    } thcfg_cfg2_t;

    typedef struct packed {
        logic [1:0] path;      // harvest_path_fet_mode
        logic [1:0] rechg;     // harvest_recharge_offset
        logic [3:0] thresh;    // harvest_regulation_threshold
    } thcfg_hcfg0_t;

    typedef enum logic {THCFG_DIRECT, THCFG_DIODE} thcfg_path_state_t;

endpackage

/* rtl/thcfg_sync.sv */
// pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none

module thcfg_sync (
    input  wire logic sys_clk,   // system clock
    input  wire logic rst,       // async reset, high
    input  wire logic clk_en,    // freezes state when low
    input  wire logic pin_in,    // asynchronous pin
    output logic      level,     // filtered level
    output logic      rise,      // one-cycle pulse on rise
    output logic      fall       // one-cycle pulse on fall
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic s1_reg, s2_reg, s3_reg;     // three-stage chain
    logic lvl_reg, rise_reg, fall_reg; // filtered outputs
    logic lvl_next, rise_next, fall_next;

    // change accepted only once stages two and three agree
    always_comb begin
        lvl_next  = lvl_reg;
        rise_next = 1'b0;
        fall_next = 1'b0;
        if (s2_reg == s3_reg && s3_reg != lvl_reg) begin
            lvl_next  = s3_reg;
            rise_next = s3_reg;
            fall_next = ~s3_reg;
        end
    end

    // first stage feeds only the second
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s1_reg   <= 1'b0;
            s2_reg   <= 1'b0;
            s3_reg   <= 1'b0;
            lvl_reg  <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else if (clk_en) begin
            s1_reg   <= pin_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            lvl_reg  <= lvl_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign level = lvl_reg;
    assign rise  = rise_reg;
    assign fall  = fall_reg;

endmodule
`default_nettype wire

/* rtl/thcfg_regs.sv */
// thermal zone and harvester configuration registers with decode logic
`timescale 1ns/10ps
`default_nettype none

// Contract
// R1: monitor select acts only supply-absent, harvester enabled
// R2: select 00: no periodic thermistor monitoring
// R3: select 01: monitor, charge cool and room
// R4: select 10: monitor, charge room and warm
// R5: select 11: monitor, charge cool, room, warm
// R6: nonzero select samples thermistor on gauge ticks
// R7: warm zone: regulation drop 100mV or 50mV
// R8: warm zone: current 0.2..0.8x, 111 full
// R9: warm fields default on chosen supply edge
// R10: drop code 00 is 150mV, 11 none
// R11: path mode: direct, auto, diode, reserved
// R12: recharge offset 70/120/170/220mV below threshold
// R13: bit 5 ignores writes, reads zero
module thcfg_regs (
    input  wire logic                sys_clk,       // 40 MHz clock
    input  wire logic                rst,           // async reset, high
    input  wire logic                clk_en,        // freezes state when low
    input  wire thcfg_pkg::thcfg_req_t reg_req,     // host register request
    output logic [7:0]               reg_rdata,     // read data
    output logic                     reg_ack,       // access done pulse
    input  wire logic                charger_input_supply,   // pin, async
    input  wire logic                harvester_interaction_enable, // level
    input  wire logic                input_edge_reset_select, // 0 rise
    input  wire logic                fuel_gauge_tick,        // gauge pulse
    input  wire logic [2:0]          thermistor_zone,        // zone result
    input  wire logic                thermistor_zone_valid,  // zone strobe
    input  wire logic                vbat_above_threshold,   // comparator
    input  wire logic                vbat_below_recharge,    // comparator
    output logic                     thermistor_sample_req,  // pulse
    output logic                     harvest_charge_allow,   // level
    output logic                     warm_zone_active,       // level
    output logic [1:0]               regulation_drop_50mv,   // steps
    output logic [3:0]               current_scale_tenths,   // x0.1
    output logic                     path_direct_on,         // switch on
    output logic                     path_ideal_diode,       // diode
    output logic                     path_by_charger,        // charger owns
    output thcfg_pkg::thcfg_hcfg0_t  harvest_cfg             // field copy
);

    // ****************************************************************
    // supply pin synchroniser
    // ****************************************************************
    logic supply_lvl, supply_rise, supply_fall; // filtered level, edges

    thcfg_sync u_supply_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .pin_in  (charger_input_supply),
        .level   (supply_lvl),
        .rise    (supply_rise),
        .fall    (supply_fall)
    );

    // ****************************************************************
    // register file
    // ****************************************************************
    thcfg_pkg::thcfg_cfg2_t  cfg2_reg, cfg2_next;   // thermal config two
    thcfg_pkg::thcfg_hcfg0_t hcfg0_reg, hcfg0_next; // harvester config
    logic [7:0]              rdata_reg, rdata_next; // read holding
    logic                    ack_reg, ack_next;     // access done
    logic                    edge_hit;              // selected edge seen
    logic                    wr_cfg2, wr_hcfg0;     // write decodes

    always_comb begin
        edge_hit = (input_edge_reset_select == thcfg_pkg::EDGE_RISE) ?
                   supply_rise : supply_fall;
        wr_cfg2  = reg_req.wr &&
                   (reg_req.addr == thcfg_pkg::THERMAL_CFG2_ADDR);
        wr_hcfg0 = reg_req.wr &&
                   (reg_req.addr == thcfg_pkg::HARVEST_CFG0_ADDR);
    end

    // writes, supply-edge defaults and read mux
    always_comb begin
        cfg2_next  = cfg2_reg;
        hcfg0_next = hcfg0_reg;
        rdata_next = rdata_reg;
        ack_next   = reg_req.wr | reg_req.rd;
        if (wr_cfg2) begin
            // bit 5 masked off so it never stores
            cfg2_next = reg_req.wdata & thcfg_pkg::CFG2_WRITE_MASK; // R13
        end
        if (wr_hcfg0) begin
            hcfg0_next = reg_req.wdata; // R11 R12
        end
        // supply edge beats a same-cycle write to the warm fields
        if (edge_hit) begin
            cfg2_next = (cfg2_next & ~thcfg_pkg::CFG2_SUPPLY_MASK) |
                        (thcfg_pkg::THERMAL_CFG2_RST &
                         thcfg_pkg::CFG2_SUPPLY_MASK); // R9
        end
        if (reg_req.rd) begin
            case (reg_req.addr)
                thcfg_pkg::THERMAL_CFG2_ADDR: begin
                    rdata_next = cfg2_reg & thcfg_pkg::CFG2_WRITE_MASK; // R13
                end
                thcfg_pkg::HARVEST_CFG0_ADDR: rdata_next = hcfg0_reg;
                default: rdata_next = 8'h00; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg2_reg  <= thcfg_pkg::THERMAL_CFG2_RST;
            hcfg0_reg <= thcfg_pkg::HARVEST_CFG0_RST;
            rdata_reg <= 8'h00;
            ack_reg   <= 1'b0;
        end else if (clk_en) begin
            cfg2_reg  <= cfg2_next;
            hcfg0_reg <= hcfg0_next;
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
        end
    end

    // ****************************************************************
    // thermistor monitoring
    // ****************************************************************
    logic       mon_active;           // select in force and nonzero
    logic [2:0] zone_reg, zone_next;  // last sampled zone
    logic       samp_reg, samp_next;  // sample request pulse
    logic       allow_reg, allow_next;
    logic       warm_reg, warm_next;
    logic [1:0] drop_reg, drop_next;
    logic [3:0] cur_reg, cur_next;

    // select only counts with supply absent and harvester enabled
    assign mon_active = ~supply_lvl && harvester_interaction_enable &&
                        (cfg2_reg.mon_sel != thcfg_pkg::MON_OFF); // R1 R2

    // zone latch and sampling schedule
    always_comb begin
        zone_next = zone_reg;
        samp_next = mon_active && fuel_gauge_tick; // R6
        if (mon_active && thermistor_zone_valid) begin
            zone_next = thermistor_zone;
        end
    end

    // zone gating of harvester charging
    always_comb begin
        allow_next = 1'b1; // no thermal gating while not monitoring
        if (mon_active) begin
            case (cfg2_reg.mon_sel)
                thcfg_pkg::MON_COOL_ROOM: begin
                    allow_next = (zone_reg == thcfg_pkg::ZONE_COOL) ||
                                 (zone_reg == thcfg_pkg::ZONE_ROOM); // R3
                end
                thcfg_pkg::MON_ROOM_WARM: begin
                    allow_next = (zone_reg == thcfg_pkg::ZONE_ROOM) ||
                                 (zone_reg == thcfg_pkg::ZONE_WARM); // R4
                end
                thcfg_pkg::MON_ALL: begin
                    allow_next = (zone_reg == thcfg_pkg::ZONE_COOL) ||
                                 (zone_reg == thcfg_pkg::ZONE_ROOM) ||
                                 (zone_reg == thcfg_pkg::ZONE_WARM); // R5
                end
                default: allow_next = 1'b1;
            endcase
        end
    end

    // warm zone regulation drop and current scale
    always_comb begin
        warm_next = mon_active && (zone_reg == thcfg_pkg::ZONE_WARM);
        drop_next = thcfg_pkg::DROP_CODE3;
        cur_next  = thcfg_pkg::CUR_FULL;
        if (warm_next) begin
            case (cfg2_reg.warm_drop)
                2'h0:    drop_next = thcfg_pkg::DROP_CODE0; // R10
                2'h1:    drop_next = thcfg_pkg::DROP_CODE1; // R7
                2'h2:    drop_next = thcfg_pkg::DROP_CODE2; // R7
                default: drop_next = thcfg_pkg::DROP_CODE3; // R10
            endcase
            if (cfg2_reg.warm_cur == thcfg_pkg::CUR_MAXC) begin
                cur_next = thcfg_pkg::CUR_FULL; // R8
            end else begin
                cur_next = thcfg_pkg::CUR_BASE +
                           {1'b0, cfg2_reg.warm_cur}; // R8
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            zone_reg  <= thcfg_pkg::ZONE_ROOM;
            samp_reg  <= 1'b0;
            allow_reg <= 1'b1;
            warm_reg  <= 1'b0;
            drop_reg  <= thcfg_pkg::DROP_CODE3;
            cur_reg   <= thcfg_pkg::CUR_FULL;
        end else if (clk_en) begin
            zone_reg  <= zone_next;
            samp_reg  <= samp_next;
            allow_reg <= allow_next;
            warm_reg  <= warm_next;
            drop_reg  <= drop_next;
            cur_reg   <= cur_next;
        end
    end

    // ****************************************************************
    // harvester path switch control
    // ****************************************************************
    thcfg_pkg::thcfg_path_state_t pst_reg, pst_next; // auto-mode state
    logic direct_reg, direct_next;
    logic diode_reg, diode_next;
    logic chgr_reg, chgr_next;

    // auto mode: diode above threshold, direct again below recharge
    always_comb begin
        pst_next = pst_reg;
        case (pst_reg)
            thcfg_pkg::THCFG_DIRECT: begin
                if (vbat_above_threshold) begin
                    pst_next = thcfg_pkg::THCFG_DIODE;
                end
            end
            thcfg_pkg::THCFG_DIODE: begin
                if (vbat_below_recharge) begin
                    pst_next = thcfg_pkg::THCFG_DIRECT; // R12
                end
            end
            default: pst_next = thcfg_pkg::THCFG_DIRECT;
        endcase
    end

    always_comb begin
        chgr_next   = supply_lvl;
        direct_next = 1'b0;
        diode_next  = 1'b0;
        if (!supply_lvl) begin
            if (!harvester_interaction_enable) begin
                direct_next = 1'b1;
            end else begin
                case (hcfg0_reg.path)
                    thcfg_pkg::PATH_DIRECT: direct_next = 1'b1; // R11
                    thcfg_pkg::PATH_AUTO: begin // R11
                        direct_next = (pst_next == thcfg_pkg::THCFG_DIRECT);
                        diode_next  = (pst_next == thcfg_pkg::THCFG_DIODE);
                    end
                    thcfg_pkg::PATH_DIODE: diode_next = 1'b1; // R11
                    default: direct_next = 1'b1; // reserved: safe on
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pst_reg    <= thcfg_pkg::THCFG_DIRECT;
            direct_reg <= 1'b1;
            diode_reg  <= 1'b0;
            chgr_reg   <= 1'b0;
        end else if (clk_en) begin
            pst_reg    <= pst_next;
            direct_reg <= direct_next;
            diode_reg  <= diode_next;
            chgr_reg   <= chgr_next;
        end
    end

    // ****************************************************************
    // outputs, all from flops
    // ****************************************************************
    assign reg_rdata             = rdata_reg;
    assign reg_ack               = ack_reg;
    assign thermistor_sample_req = samp_reg;
    assign harvest_charge_allow  = allow_reg;
    assign warm_zone_active      = warm_reg;
    assign regulation_drop_50mv  = drop_reg;
    assign current_scale_tenths  = cur_reg;
    assign path_direct_on        = direct_reg;
    assign path_ideal_diode      = diode_reg;
    assign path_by_charger       = chgr_reg;
    assign harvest_cfg           = hcfg0_reg;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    samp_off_a: assert property (clk_en && !mon_active |=> !samp_reg) // R2
        else $error("sample request while monitoring off");
    samp_tick_a: assert property (clk_en && mon_active && fuel_gauge_tick
        |=> samp_reg) // R6
        else $error("gauge tick did not raise sample request");
    gate_r1_a: assert property (clk_en && supply_lvl |=> allow_reg) // R1
        else $error("zone gating while supply present");
    cool_room_a: assert property (clk_en && mon_active &&
        cfg2_reg.mon_sel == thcfg_pkg::MON_COOL_ROOM &&
        zone_reg == thcfg_pkg::ZONE_WARM |=> !allow_reg) // R3
        else $error("warm charging allowed in cool-room mode");
    room_warm_a: assert property (clk_en && mon_active &&
        cfg2_reg.mon_sel == thcfg_pkg::MON_ROOM_WARM &&
        zone_reg == thcfg_pkg::ZONE_COOL |=> !allow_reg) // R4
        else $error("cool charging allowed in room-warm mode");
    all_zone_a: assert property (clk_en && mon_active &&
        cfg2_reg.mon_sel == thcfg_pkg::MON_ALL &&
        zone_reg == thcfg_pkg::ZONE_WARM |=> allow_reg) // R5
        else $error("warm charging refused in all-zone mode");
    warm_drop_a: assert property (clk_en && warm_next &&
        cfg2_reg.warm_drop == 2'h1 |=> drop_reg == 2'h2) // R7
        else $error("warm drop code 01 not 100mV");
    drop_zero_a: assert property (clk_en && warm_next &&
        cfg2_reg.warm_drop == 2'h0 |=> drop_reg == 2'h3) // R10
        else $error("warm drop code 00 not 150mV");
    warm_cur_a: assert property (clk_en && warm_next &&
        cfg2_reg.warm_cur == 3'h6 |=> cur_reg == 4'h8) // R8
        else $error("warm current code 110 not 0.8x");
    edge_dflt_a: assert property (clk_en && edge_hit |=>
        (cfg2_reg & thcfg_pkg::CFG2_SUPPLY_MASK) ==
        (thcfg_pkg::THERMAL_CFG2_RST & thcfg_pkg::CFG2_SUPPLY_MASK)) // R9
        else $error("warm fields not defaulted on supply edge");
    diode_mode_a: assert property (clk_en && !supply_lvl &&
        harvester_interaction_enable &&
        hcfg0_reg.path == thcfg_pkg::PATH_DIODE
        |=> diode_reg && !direct_reg) // R11
        else $error("forced diode mode not applied");
    bit5_zero_a: assert property (cfg2_reg.unused == 1'b0) // R13
        else $error("unused bit stored a one");

    warm_seen_c: cover property (warm_reg && drop_reg == 2'h1);
    edge_seen_c: cover property (edge_hit ##1 reg_req.rd);
    auto_dio_c: cover property (pst_reg == thcfg_pkg::THCFG_DIODE ##1
        pst_reg == thcfg_pkg::THCFG_DIRECT);
    samp_seen_c: cover property (samp_reg ##[1:20] thermistor_zone_valid);

endmodule
`default_nettype wire

/* sim/thcfg_host.sv */
// host-side model: register port master behind the serial interface
`timescale 1ns/10ps
`default_nettype none

module thcfg_host (
    input  wire logic                 sys_clk, // system clock
    output var thcfg_pkg::thcfg_req_t req,     // register request
    input  wire logic                 ack,     // access done pulse
    input  wire logic [7:0]           rdata    // read data
);
    initial req = '0; // idle at time zero

    // one access: held through the taking edge, answer read 1 ns after that same edge
    // released address and data show the inverse and strobes drop, so stale values never look valid
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        #1 req = '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge sys_clk);
        #1 req = '{addr: ~a, wdata: ~d, wr: 1'h0, rd: 1'h0};
        q = (ack === 1'h1) ? rdata : 8'hxx; // no ack poisons the data
    endtask
endmodule

`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the thermal and harvester config registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end

module testbench;
    int         failures = 0;    // mismatches
    int         n_checks = 0;    // comparisons
    logic       sys_clk  = 1'h0; // 40 MHz
    logic       rst      = 1'h1; // async reset
    logic       sup      = 1'h0; // charger input supply pin
    logic       hen      = 1'h1; // harvester interaction enable
    logic       en       = 1'h1; // clock enable
    logic       esel     = 1'h0; // supply edge select, 0 rise
    logic       tick     = 1'h0; // gauge schedule pulse
    logic       zv       = 1'h0; // zone strobe
    logic [2:0] zone     = 3'h2; // zone result
    logic       above    = 1'h0; // vbat above threshold
    logic       below    = 1'h0; // vbat below recharge
    logic [7:0] q, rdata;        // read data
    logic       sreq, allow, warm, direct, diode, bychg, ack;
    logic [1:0] drop;            // drop steps
    logic [3:0] scale;           // current tenths
    thcfg_pkg::thcfg_req_t   req;  // host request
    thcfg_pkg::thcfg_hcfg0_t hcfg; // harvester fields

    thcfg_regs i_thcfg_regs (.sys_clk(sys_clk), .rst(rst), .clk_en(en),
        .reg_req(req), .reg_rdata(rdata), .reg_ack(ack),
        .charger_input_supply(sup), .harvester_interaction_enable(hen),
        .input_edge_reset_select(esel),
        .fuel_gauge_tick(tick), .thermistor_zone(zone),
        .thermistor_zone_valid(zv), .vbat_above_threshold(above),
        .vbat_below_recharge(below), .thermistor_sample_req(sreq),
        .harvest_charge_allow(allow), .warm_zone_active(warm),
        .regulation_drop_50mv(drop), .current_scale_tenths(scale),
        .path_direct_on(direct), .path_ideal_diode(diode),
        .path_by_charger(bychg), .harvest_cfg(hcfg));
    thcfg_host u_host (.sys_clk(sys_clk), .req(req), .ack(ack),
        .rdata(rdata));

    always #12.5 sys_clk = ~sys_clk; // 25 ns period

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(1'h1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        u_host.xfer(1'h0, a, 8'h00, q);
        `CHK(q, e)
    endtask
    // request pulse stands only in the cycle after the tick's edge
    task automatic tick_chk(input logic e);
        cyc(1);
        tick = 1'h1;
        cyc(1);
        tick = 1'h0;
        `CHK(sreq, e)
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // reset values, unwritable bit, unmapped read
    task automatic t_regs();
        rd_chk(8'h17, 8'h00);
        rd_chk(8'h18, 8'h00);
        wr(8'h17, 8'hff);
        rd_chk(8'h17, 8'hdf);
        wr(8'h18, 8'h9c);
        rd_chk(8'h18, 8'h9c);
        `CHK(hcfg.rechg, 2'h1)
        en = 1'h0;
        wr(8'h18, 8'h11);
        en = 1'h1;
        rd_chk(8'h18, 8'h9c);
        rd_chk(8'h20, 8'h00);
    endtask
    // every select code against cool, room and warm zones
    task automatic t_mon();
        logic [1:0] s, d;
        logic [2:0] c;
        logic       act, wa, ea;
        for (int i = 0; i < 4; i++) begin
            s = i[1:0];
            d = ~s;
            c = {s[0], s};
            act = (s != 2'h0);
            wr(8'h17, {s, 1'h0, d, c});
            for (int z = 1; z < 4; z++) begin
                zone = z[2:0];
                zv = 1'h1;
                cyc(1);
                zv = 1'h0;
                cyc(2);
                wa = act && z == 3;
                ea = !act || z == 2 || (z == 1 && s[0]) || (z == 3 && s[1]);
                `CHK(allow, ea)
                `CHK(warm, wa)
                `CHK(drop, wa ? 2'h3 - d : 2'h0)
                `CHK(scale, (!wa || c == 3'h7) ? 4'ha : 4'h2 + c)
            end
            tick_chk(act);
        end
    endtask
    // harvester interaction disabled: monitoring has no effect
    task automatic t_gate();
        hen = 1'h0;
        cyc(3);
        `CHK({allow, warm}, 2'h2)
        tick_chk(1'h0);
        hen = 1'h1;
    endtask
    // selected supply edge restores starred fields, the other does not
    task automatic t_edge();
        wr(8'h17, 8'h5b);
        sup = 1'h1;
        cyc(6);
        `CHK(bychg, 1'h1)
        rd_chk(8'h17, 8'h40);
        wr(8'h17, 8'h5b);
        sup = 1'h0;
        cyc(6);
        rd_chk(8'h17, 8'h5b);
        esel = 1'h1;
        sup = 1'h1;
        cyc(6);
        rd_chk(8'h17, 8'h5b);
        sup = 1'h0;
        cyc(6);
        rd_chk(8'h17, 8'h40);
        esel = 1'h0;
    endtask
    task automatic path_chk(input logic [7:0] v, input logic [1:0] e);
        wr(8'h18, v);
        cyc(2);
        `CHK({direct, diode}, e)
    endtask
    // path modes, auto by comparators, disabled interaction
    task automatic t_path();
        path_chk(8'h05, 2'h2);
        path_chk(8'h85, 2'h1);
        path_chk(8'hc5, 2'h2);
        above = 1'h1;
        path_chk(8'h65, 2'h1);
        above = 1'h0;
        below = 1'h1;
        path_chk(8'h65, 2'h2);
        hen = 1'h0;
        path_chk(8'h85, 2'h2);
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        #1 rst = 1'h0;
        t_regs();
        t_mon();
        t_gate();
        t_edge();
        t_path();
        end_sim();
    end
    // watchdog: the run needs well under 1000 cycles
    initial begin
        #200000;
        failures++;
        end_sim();
    end
endmodule

`default_nettype wire
